// >>> ism_arbiter.sv
// fixed-priority pick of the lowest unmasked pending source
// assumes source 0 has the highest priority
`timescale 1ns/1ps
module ism_arbiter import ism_pkg::*; (
  input wire logic [NSRC-1:0] pend,
  input wire logic [NSRC-1:0] mask,
  output logic valid,
  output logic [2:0] idx
);
  logic [NSRC-1:0] req;
  logic [NSRC:0] seen;
  logic [3*NSRC+2:0] acc;

  assign req = pend & ~mask;
  assign seen[0] = 1'b0;
  assign acc[2:0] = 3'h0;

  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_pick
      assign seen[i+1] = seen[i] | req[i];
      assign acc[3*i+5:3*i+3] = acc[3*i+2:3*i] | ((req[i] & ~seen[i]) ? 3'(i) : 3'h0);
    end
  endgenerate

  assign valid = seen[NSRC];
  assign idx = acc[3*NSRC+2:3*NSRC];
endmodule : ism_arbiter

// >>> ism_bank.sv
// eight register-bank context slots: one exchange port, one software port
// read ports are combinational so a read and a write share one edge
`timescale 1ns/1ps
module ism_bank import ism_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] xidx,
  output ism_slot_t xslot,
  input wire logic [2:0] sidx,
  output ism_slot_t sslot,
  input wire logic we,
  input wire logic [2:0] widx,
  input wire ism_slot_t wslot
);
  ism_slot_t slot [NBANK];

  assign xslot = slot[xidx];
  assign sslot = slot[sidx];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NBANK; k++) begin
        slot[k] <= '0;
      end
    end else if (we) begin
      slot[widx] <= wslot;
    end
  end
endmodule : ism_bank

// >>> ism_mem_model.sv
// data bus partner: memory and sfr space, single-cycle ack after lat waits
// assumes the block holds each request until its ack
`timescale 1ns/1ps
module ism_mem_model (
  input wire logic clk,
  input wire logic req,
  input wire logic we,
  input wire logic wide,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [2:0] lat,
  output logic [15:0] rdata,
  output logic ack
);
  logic [15:0] mem [logic [15:0]];
  int n = 0;
  initial begin
    rdata = 16'h0000;
    ack = 1'b0;
  end
  // ----------------------------------------
  // answer
  // ----------------------------------------
  always @(posedge clk) begin
    ack <= 1'b0;
    // toggles outside a read answer so stale data never looks valid
    rdata <= ~rdata;
    if (req && !ack && n < lat) begin
      n <= n + 1;
    end else if (req && !ack) begin
      n <= 0;
      ack <= 1'b1;
      if (we) begin
        mem[addr] = wide ? wdata : {8'h00, wdata[7:0]};
      end else begin
        rdata <= wide ? mem[addr] : {8'h00, mem[addr][7:0]};
      end
    end
  end
endmodule : ism_mem_model

// >>> ism_pkg.sv
// interrupt service modes: shared constants, types and register map
// assumes a single core clock and an APB master with 8-bit byte addresses
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package ism_pkg;
  localparam int unsigned NSRC = 8;
  localparam int unsigned NBANK = 8;
  localparam int unsigned EV_W = 4;

  // register map, byte addresses
  localparam logic [7:0] ADDR_MASK = 8'h00;
  localparam logic [7:0] ADDR_BSE = 8'h04;
  localparam logic [7:0] ADDR_XEN = 8'h08;
  localparam logic [7:0] ADDR_PEND = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_EV_STAT = 8'h14;
  localparam logic [7:0] ADDR_EV_EN = 8'h18;
  localparam logic [7:0] ADDR_EV_CLR = 8'h1c;
  localparam logic [1:0] DESC_PAGE = 2'h1;
  localparam logic [2:0] BVEC_PAGE = 3'h4;

  // reset values
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] BSE_RST = 8'h00;
  localparam logic [7:0] XEN_RST = 8'h00;
  localparam logic [3:0] EV_EN_RST = 4'h0;

  // field positions
  localparam int unsigned CTL_COUNT_LSB = 0;
  localparam int unsigned CTL_WIDE_BIT = 8;
  localparam int unsigned CTL_DIR_BIT = 9;
  localparam int unsigned CTL_DONE_LSB = 16;
  localparam int unsigned STW_FSM_LSB = 0;
  localparam int unsigned STW_BANK_LSB = 4;
  localparam int unsigned STW_HOLD_BIT = 8;
  localparam int unsigned EV_XFER = 0;
  localparam int unsigned EV_CNTVEC = 1;
  localparam int unsigned EV_CSW = 2;
  localparam int unsigned EV_BADRET = 3;

  // vector table: two bytes per source, source 0 first
  localparam logic [15:0] VEC_TABLE_BASE = 16'h0006;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VFETCH = 3'b001,
    ST_XCHG = 3'b010,
    ST_XRD = 3'b011,
    ST_XWR = 3'b100
  } ism_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] psw;
  } ism_ctx_t;

  typedef struct packed {
    ism_ctx_t ctx;
    logic [2:0] prev_bank;
    logic by_brk;
  } ism_slot_t;

  typedef struct packed {
    logic [15:0] sfr_addr;
    logic [15:0] mem_ptr;
    logic [7:0] count;
    logic wide;
    logic to_sfr;
    logic [7:0] done;
  } ism_desc_t;
endpackage : ism_pkg

// >>> ism_top.sv
// interrupt service modes: transfer service, bank context switch, vectoring
// assumes an APB master, a data bus slave answering with a one-cycle ack,
// and a core that stops while HOLD is high and obeys CTX_LOAD / VEC_REQ
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ism_top import ism_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NSRC-1:0] IRQ_SET,
  input wire logic CORE_EI,
  input wire logic [15:0] CORE_PC,
  input wire logic [15:0] CORE_PSW,
  input wire logic BRK_CS,
  input wire logic [7:0] BRK_OPCODE2,
  input wire logic RET_IRQ,
  input wire logic RET_BRK,
  output logic HOLD,
  output logic CTX_LOAD,
  output logic CTX_PSW_LOAD,
  output logic [15:0] CTX_PC,
  output logic [15:0] CTX_PSW,
  output logic [2:0] REG_BANK,
  output logic VEC_REQ,
  output logic [2:0] VEC_ID,
  output logic DBUS_REQ,
  output logic DBUS_WE,
  output logic DBUS_WIDE,
  output logic [15:0] DBUS_ADDR,
  output logic [15:0] DBUS_WDATA,
  input wire logic [15:0] DBUS_RDATA,
  input wire logic DBUS_ACK,
  output logic IRQ
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ism_state_t state_q;
  ism_state_t next_state;
  logic [NSRC-1:0] mask_q;
  logic [NSRC-1:0] bse_q;
  logic [NSRC-1:0] xen_q;
  logic [NSRC-1:0] pend_q;
  logic [EV_W-1:0] ev_stat_q;
  logic [EV_W-1:0] ev_en_q;
  ism_desc_t desc_q [NSRC];
  logic [2:0] src_q;
  logic [2:0] sel_q;
  logic by_brk_q;
  logic [2:0] win;
  logic win_valid;
  ism_slot_t xslot;
  ism_slot_t sslot;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire wr_acc = PSEL & PENABLE & PREADY & PWRITE;
  wire aligned = PADDR[1:0] == 2'b00;
  wire hit_mask = PADDR == ADDR_MASK;
  wire hit_bse = PADDR == ADDR_BSE;
  wire hit_xen = PADDR == ADDR_XEN;
  wire hit_pend = PADDR == ADDR_PEND;
  wire hit_state = PADDR == ADDR_STATE;
  wire hit_evstat = PADDR == ADDR_EV_STAT;
  wire hit_even = PADDR == ADDR_EV_EN;
  wire hit_evclr = PADDR == ADDR_EV_CLR;
  wire hit_desc = PADDR[7:6] == DESC_PAGE && aligned;
  wire hit_bvec = PADDR[7:5] == BVEC_PAGE && aligned;
  wire [2:0] desc_idx = PADDR[5:3];
  wire desc_ctl = PADDR[2];
  wire [2:0] bvec_idx = PADDR[4:2];
  wire mapped = hit_mask | hit_bse | hit_xen | hit_pend | hit_state | hit_evstat | hit_even
                | hit_evclr | hit_desc | hit_bvec;

  logic [31:0] rd_word;
  ism_desc_t rd_desc;

  assign rd_desc = desc_q[desc_idx];

  always_comb begin
    rd_word = 32'h0;
    if (hit_mask) rd_word[NSRC-1:0] = mask_q;
    if (hit_bse) rd_word[NSRC-1:0] = bse_q;
    if (hit_xen) rd_word[NSRC-1:0] = xen_q;
    if (hit_pend) rd_word[NSRC-1:0] = pend_q;
    if (hit_state) begin
      rd_word[STW_FSM_LSB +: 3] = state_q;
      rd_word[STW_BANK_LSB +: 3] = REG_BANK;
      rd_word[STW_HOLD_BIT] = HOLD;
    end
    if (hit_evstat) rd_word[EV_W-1:0] = ev_stat_q;
    if (hit_even) rd_word[EV_W-1:0] = ev_en_q;
    if (hit_desc && !desc_ctl) rd_word = {rd_desc.sfr_addr, rd_desc.mem_ptr};
    if (hit_desc && desc_ctl) begin
      rd_word[CTL_COUNT_LSB +: 8] = rd_desc.count;
      rd_word[CTL_WIDE_BIT] = rd_desc.wide;
      rd_word[CTL_DIR_BIT] = rd_desc.to_sfr;
      rd_word[CTL_DONE_LSB +: 8] = rd_desc.done;
    end
    if (hit_bvec) rd_word[15:0] = sslot.ctx.pc;
  end

  // answer registered in the setup cycle: every access completes without wait
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      PRDATA <= (setup && !PWRITE) ? rd_word : 32'h0;
      PSLVERR <= setup & ~mapped;
    end
  end

  // ---------------------------------------------------------------
  // acceptance and mode choice
  // ---------------------------------------------------------------
  ism_arbiter u_arb (
    .pend(pend_q),
    .mask(mask_q),
    .valid(win_valid),
    .idx(win)
  );

  ism_desc_t wdesc;
  ism_desc_t cdesc;
  assign wdesc = desc_q[win];
  assign cdesc = desc_q[src_q];

  wire idle = state_q == ST_IDLE;
  wire ret_any = RET_IRQ | RET_BRK;
  wire ret_go = idle & ret_any;
  wire brk_go = idle & ~ret_any & BRK_CS;
  wire irq_go = idle & ~ret_any & ~BRK_CS & win_valid;
  wire at_count = wdesc.done == wdesc.count;
  wire take_xfer = irq_go & xen_q[win] & ~at_count;
  wire take_cntvec = irq_go & xen_q[win] & at_count;
  wire take_cs = irq_go & ~xen_q[win] & bse_q[win] & CORE_EI;
  wire take_plain = irq_go & ~xen_q[win] & ~bse_q[win] & CORE_EI;
  wire ret_ok = ret_go & (RET_BRK ? xslot.by_brk : ~xslot.by_brk);
  wire ret_bad = ret_go & ~ret_ok;
  wire xfer_end = state_q == ST_XWR && DBUS_ACK;
  wire vec_go = take_cntvec | take_plain;

  always_comb begin
    next_state = state_q;
    case (state_q)
      ST_IDLE: begin
        if (brk_go) next_state = ST_XCHG;
        else if (take_cs) next_state = ST_VFETCH;
        else if (take_xfer) next_state = ST_XRD;
      end
      ST_VFETCH: if (DBUS_ACK) next_state = ST_XCHG;
      ST_XCHG: next_state = ST_IDLE;
      ST_XRD: if (DBUS_ACK) next_state = ST_XWR;
      ST_XWR: if (DBUS_ACK) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      src_q <= 3'h0;
      sel_q <= 3'h0;
      by_brk_q <= 1'b0;
    end else begin
      state_q <= next_state;
      if (irq_go) src_q <= win;
      if (brk_go) sel_q <= BRK_OPCODE2[2:0];
      if (state_q == ST_VFETCH && DBUS_ACK) sel_q <= DBUS_RDATA[2:0];
      if (brk_go | take_cs) by_brk_q <= brk_go;
    end
  end

  // ---------------------------------------------------------------
  // data bus: vector byte fetch and transfer service moves
  // ---------------------------------------------------------------
  logic [15:0] next_addr;
  logic next_we;
  logic next_wide;
  wire [2:0] nsrc = idle ? win : src_q;
  ism_desc_t ndesc;
  assign ndesc = desc_q[nsrc];

  always_comb begin
    next_addr = 16'h0;
    next_we = 1'b0;
    next_wide = 1'b0;
    case (next_state)
      ST_VFETCH: next_addr = VEC_TABLE_BASE + {12'h0, nsrc, 1'b0};
      ST_XRD: begin
        next_addr = ndesc.to_sfr ? ndesc.mem_ptr : ndesc.sfr_addr;
        next_wide = ndesc.wide;
      end
      ST_XWR: begin
        next_addr = ndesc.to_sfr ? ndesc.sfr_addr : ndesc.mem_ptr;
        next_wide = ndesc.wide;
        next_we = 1'b1;
      end
      default: next_addr = 16'h0;
    endcase
  end

  // the read item is carried to the write phase untouched by the core
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      DBUS_REQ <= 1'b0;
      DBUS_WE <= 1'b0;
      DBUS_WIDE <= 1'b0;
      DBUS_ADDR <= 16'h0;
      DBUS_WDATA <= 16'h0;
    end else begin
      DBUS_REQ <= next_state == ST_VFETCH || next_state == ST_XRD || next_state == ST_XWR;
      DBUS_WE <= next_we;
      DBUS_WIDE <= next_wide;
      DBUS_ADDR <= next_addr;
      if (state_q == ST_XRD && DBUS_ACK) begin
        DBUS_WDATA <= cdesc.wide ? DBUS_RDATA : {8'h0, DBUS_RDATA[7:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // bank context store
  // ---------------------------------------------------------------
  logic bank_we;
  logic [2:0] bank_widx;
  ism_slot_t bank_wslot;
  ism_ctx_t core_ctx;
  assign core_ctx = '{pc: CORE_PC, psw: CORE_PSW};

  wire [2:0] xidx = (state_q == ST_XCHG) ? sel_q : REG_BANK;
  wire fsm_we = state_q == ST_XCHG || ret_ok;
  wire apb_bvec_we = wr_acc & hit_bvec;

  // switch swaps the slot: old context in, stored pc out; return writes back only the core pc, stored context out
  always_comb begin
    bank_we = fsm_we | apb_bvec_we;
    bank_widx = bvec_idx;
    bank_wslot = sslot;
    bank_wslot.ctx.pc = PWDATA[15:0];
    if (state_q == ST_XCHG) begin
      bank_widx = sel_q;
      bank_wslot = '{ctx: core_ctx, prev_bank: REG_BANK, by_brk: by_brk_q};
    end else if (ret_ok) begin
      bank_widx = REG_BANK;
      bank_wslot = xslot;
      bank_wslot.ctx.pc = CORE_PC;
    end
  end

  ism_bank u_bank (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .xidx(xidx),
    .xslot(xslot),
    .sidx(bvec_idx),
    .sslot(sslot),
    .we(bank_we),
    .widx(bank_widx),
    .wslot(bank_wslot)
  );

  // ---------------------------------------------------------------
  // core-facing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      HOLD <= 1'b0;
      CTX_LOAD <= 1'b0;
      CTX_PSW_LOAD <= 1'b0;
      CTX_PC <= 16'h0;
      CTX_PSW <= 16'h0;
      REG_BANK <= 3'h0;
      VEC_REQ <= 1'b0;
      VEC_ID <= 3'h0;
    end else begin
      HOLD <= next_state != ST_IDLE;
      CTX_LOAD <= state_q == ST_XCHG || ret_ok;
      CTX_PSW_LOAD <= ret_ok;
      if (state_q == ST_XCHG || ret_ok) CTX_PC <= xslot.ctx.pc;
      if (ret_ok) CTX_PSW <= xslot.ctx.psw;
      if (state_q == ST_XCHG) REG_BANK <= sel_q;
      else if (ret_ok) REG_BANK <= xslot.prev_bank;
      VEC_REQ <= vec_go;
      if (vec_go) VEC_ID <= win;
    end
  end

  // ---------------------------------------------------------------
  // software registers, request flags, descriptors
  // ---------------------------------------------------------------
  logic [NSRC-1:0] pend_clr;
  always_comb begin
    pend_clr = '0;
    if (xfer_end) pend_clr[src_q] = 1'b1;
    if (vec_go | take_cs) pend_clr[win] = 1'b1;
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RST;
      bse_q <= BSE_RST;
      xen_q <= XEN_RST;
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | IRQ_SET; // new request beats the clear
      if (wr_acc && hit_mask) mask_q <= PWDATA[NSRC-1:0];
      if (wr_acc && hit_bse) bse_q <= PWDATA[NSRC-1:0];
      if (wr_acc && hit_xen) xen_q <= PWDATA[NSRC-1:0];
    end
  end

  // a software write of a word overrides the hardware advance of that edge
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NSRC; k++) desc_q[k] <= '0;
    end else begin
      if (xfer_end) begin
        desc_q[src_q].done <= cdesc.done + 8'h01;
        desc_q[src_q].mem_ptr <= cdesc.mem_ptr + (cdesc.wide ? 16'h0002 : 16'h0001);
      end
      if (wr_acc && hit_desc && !desc_ctl) begin
        desc_q[desc_idx].sfr_addr <= PWDATA[31:16];
        desc_q[desc_idx].mem_ptr <= PWDATA[15:0];
      end
      if (wr_acc && hit_desc && desc_ctl) begin
        desc_q[desc_idx].count <= PWDATA[CTL_COUNT_LSB +: 8];
        desc_q[desc_idx].wide <= PWDATA[CTL_WIDE_BIT];
        desc_q[desc_idx].to_sfr <= PWDATA[CTL_DIR_BIT];
        desc_q[desc_idx].done <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // event status and interrupt line
  // ---------------------------------------------------------------
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] next_ev_stat;
  always_comb begin
    ev_set = '0;
    ev_set[EV_XFER] = xfer_end;
    ev_set[EV_CNTVEC] = take_cntvec;
    ev_set[EV_CSW] = state_q == ST_XCHG;
    ev_set[EV_BADRET] = ret_bad;
  end
  wire [EV_W-1:0] ev_clr = (wr_acc && hit_evclr) ? PWDATA[EV_W-1:0] : '0;
  assign next_ev_stat = (ev_stat_q & ~ev_clr) | ev_set;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat_q <= '0;
      ev_en_q <= EV_EN_RST;
      IRQ <= 1'b0;
    end else begin
      ev_stat_q <= next_ev_stat;
      if (wr_acc && hit_even) ev_en_q <= PWDATA[EV_W-1:0];
      IRQ <= |(next_ev_stat & (wr_acc && hit_even ? PWDATA[EV_W-1:0] : ev_en_q));
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking ast_clk @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  AST_XFER_MOVE: assert property ((state_q == ST_XRD && DBUS_ACK && cdesc.wide)
    |=> state_q == ST_XWR && DBUS_WE && DBUS_WDATA == $past(DBUS_RDATA))
    else $error("transfer item not carried to write phase");
  AST_XFER_HOLD: assert property ((state_q == ST_XRD) |-> HOLD throughout (state_q == ST_XRD))
    else $error("core not held during transfer");
  AST_PEND_CLR: assert property ((xfer_end && !IRQ_SET[src_q])
    |=> !pend_q[$past(src_q)] && !HOLD)
    else $error("request flag not cleared at transfer end");
  AST_COUNT_VEC: assert property (take_cntvec |=> VEC_REQ && VEC_ID == $past(win) && state_q == ST_IDLE)
    else $error("count reached but no vectored request");
  AST_CSE_ONLY: assert property ((idle && next_state == ST_VFETCH) |-> bse_q[win] && CORE_EI)
    else $error("switch without bank switch enable");
  AST_BANK_FROM_VEC: assert property ((state_q == ST_VFETCH && DBUS_ACK)
    |=> ##1 REG_BANK == $past(DBUS_RDATA[2:0], 2) && CTX_LOAD)
    else $error("bank not taken from vector byte");
  AST_XCHG: assert property ((state_q == ST_XCHG) |=> CTX_LOAD && CTX_PC == $past(xslot.ctx.pc))
    else $error("vector not loaded from bank");
  AST_BRK_BANK: assert property (brk_go |=> ##1 REG_BANK == $past(BRK_OPCODE2[2:0], 2))
    else $error("break selected wrong bank");
  AST_RET_MATCH: assert property ((ret_go && RET_BRK != xslot.by_brk) |=> !CTX_LOAD && ev_stat_q[EV_BADRET])
    else $error("mismatched return accepted");
  AST_RET_PSW: assert property (ret_ok |=> CTX_PSW_LOAD && CTX_PSW == $past(xslot.ctx.psw))
    else $error("return did not restore status word");
  AST_ACCEPT: assert property ((idle && (next_state == ST_XRD || next_state == ST_VFETCH))
    |-> pend_q[win] && !mask_q[win])
    else $error("service begun for unaccepted source");

  COV_XFER: cover property (xfer_end);
  COV_CSW: cover property (take_cs ##[1:20] CTX_LOAD);
  COV_BRK: cover property (brk_go ##2 CTX_LOAD);
  COV_CNTVEC: cover property (take_cntvec);
endmodule : ism_top

// >>> test_interrupt_service_modes.sv
// bench for the interrupt service block: apb master, core pulses, checks
// assumes ism_mem_model answers the data bus
`timescale 1ns/1ps
module test_interrupt_service_modes import ism_pkg::*;;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = 0, irq_set = 0, op2 = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic ei = 0, brk = 0, ret_irq = 0, ret_brk = 0, hold, cload, pload, vreq, dreq, dwe, dwide, dack, irq;
  logic [15:0] pc = 0, psw = 0, cpc, cpsw, daddr, dwdata, drdata, d, psw0;
  logic [2:0] bank, vid, lat = 0;
  int mismatches = 0, total_checks = 0, b, b2;
  int bvec[8];
  always #10 clk = ~clk;
  ism_top ism_top_i (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ_SET(irq_set),
    .CORE_EI(ei), .CORE_PC(pc), .CORE_PSW(psw), .BRK_CS(brk), .BRK_OPCODE2(op2), .RET_IRQ(ret_irq),
    .RET_BRK(ret_brk), .HOLD(hold), .CTX_LOAD(cload), .CTX_PSW_LOAD(pload), .CTX_PC(cpc), .CTX_PSW(cpsw),
    .REG_BANK(bank), .VEC_REQ(vreq), .VEC_ID(vid), .DBUS_REQ(dreq), .DBUS_WE(dwe), .DBUS_WIDE(dwide),
    .DBUS_ADDR(daddr), .DBUS_WDATA(dwdata), .DBUS_RDATA(drdata), .DBUS_ACK(dack), .IRQ(irq));
  ism_mem_model mem_i (.clk(clk), .req(dreq), .we(dwe), .wide(dwide), .addr(daddr), .wdata(dwdata),
    .lat(lat), .rdata(drdata), .ack(dack));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    // pready, prdata and pslverr are taken at the rising edge that ends the access
    do @(posedge clk); while (!(psel && penable && pready === 1'b1) && ++n < 50);
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wait_lvl(ref logic s, input logic v);
    int n = 0;
    do @(negedge clk); while (s !== v && ++n < 300);
    if (n >= 300) begin
      mismatches++;
      end_sim();
    end
  endtask : wait_lvl
  // core strobes from one word; pc, psw, opcode and bus latency from a second word
  task automatic pulse(input logic [10:0] v, input logic [15:0] p);
    @(posedge clk);
    {ret_brk, ret_irq, brk, irq_set} <= v;
    pc <= p;
    psw <= ~p;
    op2 <= p[7:0];
    lat <= p[10:8];
    @(posedge clk);
    {ret_brk, ret_irq, brk, irq_set} <= 11'h000;
  endtask : pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(2));
    repeat (12) @(posedge clk);
    arst_n <= 1;
    repeat (2) @(posedge clk);
    apb(0, ADDR_MASK, 0);
    chk("mask", 32'(MASK_RST), q);
    apb(0, 8'h24, 0);
    chk("slverr", 1, 32'(err));
    apb(0, 8'h86, 0);
    chk("unaligned", 1, 32'(err));
    for (int i = 0; i < 8; i++) begin
      bvec[i] = int'($urandom & 32'hffff);
      apb(1, 8'h80 + 8'(4 * i), bvec[i]);
    end
    b = 1 + int'($urandom % 7);
    mem_i.mem[VEC_TABLE_BASE + 16'h0002] = 16'h00f8 | 16'(b);
    apb(1, ADDR_MASK, 0);
    apb(1, ADDR_EV_EN, 32'hf);
    apb(1, ADDR_BSE, 32'h2);
    apb(1, ADDR_XEN, 32'h4);
    ei <= 1;
    d = 16'($urandom);
    psw0 = ~d;
    pulse(11'h002, d);
    wait_lvl(cload, 1);
    chk("switch pc", bvec[b], 32'(cpc));
    chk("switch bank", b, 32'(bank));
    apb(0, 8'h80 + 8'(4 * b), 0);
    chk("saved pc", 32'(d), q);
    bvec[b] = int'(d ^ 16'h5a5a);
    pulse(11'h200, d ^ 16'h5a5a);
    wait_lvl(cload, 1);
    chk("ret pc", 32'(d), 32'(cpc));
    chk("ret psw", 32'(psw0), 32'(cpsw));
    chk("ret psw load", 1, 32'(pload));
    chk("ret bank", 0, 32'(bank));
    apb(0, 8'h80 + 8'(4 * b), 0);
    chk("reentry", bvec[b], q);
    d = 16'($urandom) | 16'h0001;
    b2 = int'(d[2:0]);
    pulse(11'h100, d);
    wait_lvl(cload, 1);
    chk("brk pc", bvec[b2], 32'(cpc));
    chk("brk bank", b2, 32'(bank));
    apb(0, ADDR_STATE, 0);
    chk("state", 32'(b2) << STW_BANK_LSB, q);
    pulse(11'h200, 0);
    repeat (6) begin
      @(negedge clk);
      chk("wrong return", 0, 32'(cload));
    end
    pulse(11'h400, 0);
    wait_lvl(cload, 1);
    chk("brk ret pc", 32'(d), 32'(cpc));
    apb(1, ADDR_MASK, 32'h8);
    pulse(11'h008, 16'($urandom));
    repeat (6) begin
      @(negedge clk);
      chk("masked", 0, 32'(vreq));
    end
    apb(1, ADDR_MASK, 0);
    wait_lvl(vreq, 1);
    chk("vec id", 3, 32'(vid));
    d = 16'($urandom);
    mem_i.mem[16'hff20] = d;
    apb(1, 8'h50, 32'hff20_0400);
    apb(1, 8'h54, 32'h0000_0102);
    for (int k = 0; k < 2; k++) begin
      pulse(11'h004, 16'($urandom));
      wait_lvl(hold, 1);
      chk("bus while held", 1, 32'(dreq));
      wait_lvl(hold, 0);
      apb(0, ADDR_PEND, 0);
      chk("flag cleared", 0, q & 32'h4);
      if (k == 0) chk("moved", 32'(d), 32'(mem_i.mem[16'h0400]));
    end
    apb(0, 8'h54, 0);
    chk("done", 2, 32'(q[23:16]));
    pulse(11'h004, 16'($urandom));
    wait_lvl(vreq, 1);
    chk("count vec", 2, 32'(vid));
    // narrow move the other way: memory byte into the sfr, pointer steps by one
    d = 16'($urandom);
    mem_i.mem[16'h0404] = d;
    apb(1, 8'h54, 32'h0000_0201);
    pulse(11'h004, 16'($urandom));
    wait_lvl(hold, 1);
    wait_lvl(hold, 0);
    chk("narrow moved", 32'({8'h00, d[7:0]}), 32'(mem_i.mem[16'hff20]));
    apb(0, 8'h50, 0);
    chk("ptr step", 32'hff20_0405, q);
    apb(0, ADDR_EV_STAT, 0);
    chk("events", 32'hf, q);
    apb(1, ADDR_EV_EN, 0);
    repeat (2) @(negedge clk);
    chk("irq masked", 0, 32'(irq));
    apb(1, ADDR_EV_EN, 32'hf);
    repeat (2) @(negedge clk);
    chk("irq on", 1, 32'(irq));
    apb(1, ADDR_EV_CLR, 32'hf);
    repeat (2) @(negedge clk);
    chk("irq cleared", 0, 32'(irq));
    end_sim();
  end
endmodule : test_interrupt_service_modes
